/* pkg/dpsem_map.svh */
// Offsets, field positions and timing counts of the semaphore host
`ifndef DPSEM_MAP_SVH
`define DPSEM_MAP_SVH
`define DPSEM_FLAG_COUNT     8
`define DPSEM_INDEX_W        3
`define DPSEM_DATA_W         16
`define DPSEM_DATA_LSB       0
`define DPSEM_CLK_NS         10
`define DPSEM_ACCESS_NS      55
`define DPSEM_ACCESS_CYC     ((`DPSEM_ACCESS_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_RECOVER_NS     20
`define DPSEM_RECOVER_CYC    ((`DPSEM_RECOVER_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`endif

/* pkg/dpsem_pkg.sv */
// Types of the semaphore host
package dpsem_pkg;
	typedef enum logic [1:0] {
		DPSEM_CMD_CLAIM   = 2'h0,
		DPSEM_CMD_RELEASE = 2'h1,
		DPSEM_CMD_POLL    = 2'h2,
		DPSEM_CMD_INIT    = 2'h3
	} dpsem_cmd_t;
	typedef enum logic [2:0] {
		DPSEM_IDLE   = 3'h0,
		DPSEM_WRITE  = 3'h1,
		DPSEM_GAP    = 3'h2,
		DPSEM_READ   = 3'h3,
		DPSEM_DONE   = 3'h4
	} dpsem_state_t;
endpackage : dpsem_pkg

/* pkg/dpsem_cyc_if.sv */
// Carries one pin-cycle request and its completion between host modules
`timescale 1ns/1ps
interface dpsem_cyc_if;
	logic       start;
	logic       isWrite;
	logic [2:0] index;
	logic       wrBit;
	logic       done;
	logic       rdBit;
	modport seq (output start, output isWrite, output index, output wrBit,
		input done, input rdBit);
	modport pins (input start, input isWrite, input index, input wrBit,
		output done, output rdBit);
endinterface : dpsem_cyc_if

/* rtl/dpsem_pin_cycle.sv */
// Drives one semaphore read or write cycle on the device pins
`timescale 1ns/1ps
`include "dpsem_map.svh"
module dpsem_pin_cycle import dpsem_pkg::*; #(
	parameter int DATA_W  = `DPSEM_DATA_W,
	parameter int ACC_CYC = `DPSEM_ACCESS_CYC,
	parameter int REC_CYC = `DPSEM_RECOVER_CYC
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	dpsem_cyc_if.pins              cyc,
	output logic                   semaphoreSelectN,
	output logic                   outputEnableN,
	output logic                   writeN,
	output logic [2:0]             flagIndexLines,
	output logic [DATA_W-1:0]      dataOut,
	output logic                   dataOe,
	input  wire logic [DATA_W-1:0] dataIn
);
	initial begin
		if (DATA_W < 1 || ACC_CYC < 1 || REC_CYC < 1 || ACC_CYC > 255
			|| REC_CYC > 255)
			$error("dpsem_pin_cycle: bad parameter");
	end

	typedef enum logic [1:0] {
		PC_IDLE = 2'h0,
		PC_ACT  = 2'h1,
		PC_REC  = 2'h2
	} dpsem_pc_t;

	dpsem_pc_t  state_r;
	logic [7:0] cnt_r;
	logic       isWrite_r;
	logic       s1_r;
	logic       s2_r;
	logic       s3_r;
	logic       rdBit_r;
	logic       done_r;

	// Three-stage sampling of the flag bit; a change counts once two agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			// Every data line carries the flag, so one line is enough
			s1_r <= dataIn[`DPSEM_DATA_LSB];
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r          <= PC_IDLE;
			cnt_r            <= 8'h00;
			isWrite_r        <= 1'b0;
			semaphoreSelectN <= 1'b1;
			outputEnableN    <= 1'b1;
			writeN           <= 1'b1;
			flagIndexLines   <= 3'h0;
			dataOut          <= '0;
			dataOe           <= 1'b0;
			done_r           <= 1'b0;
			rdBit_r          <= 1'b1;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				PC_IDLE: begin
					if (cyc.start) begin
						state_r          <= PC_ACT;
						cnt_r            <= 8'(ACC_CYC + 2);
						isWrite_r        <= cyc.isWrite;
						flagIndexLines   <= cyc.index;
						semaphoreSelectN <= 1'b0;
						outputEnableN    <= cyc.isWrite;
						writeN           <= !cyc.isWrite;
						// Only the lowest data line matters on writes
						dataOut          <= {DATA_W{cyc.wrBit}};
						dataOe           <= cyc.isWrite;
					end
				end
				PC_ACT: begin
					if (cnt_r == 8'h01) begin
						state_r          <= PC_REC;
						cnt_r            <= 8'(REC_CYC);
						// Dropping select ends the held read value
						semaphoreSelectN <= 1'b1;
						outputEnableN    <= 1'b1;
						writeN           <= 1'b1;
						dataOe           <= 1'b0;
						if (!isWrite_r && s2_r == s3_r)
							rdBit_r <= s3_r;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				PC_REC: begin
					if (cnt_r == 8'h01) begin
						state_r <= PC_IDLE;
						done_r  <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: state_r <= PC_IDLE;
			endcase
		end
	end

	assign cyc.done  = done_r;
	assign cyc.rdBit = rdBit_r;
endmodule : dpsem_pin_cycle

/* rtl/dpsem_host.sv */
// Host side controller for one port of a dual-port semaphore block
`timescale 1ns/1ps
`include "dpsem_map.svh"
module dpsem_host import dpsem_pkg::*; #(
	parameter int DATA_W  = `DPSEM_DATA_W,
	parameter int ACC_CYC = `DPSEM_ACCESS_CYC,
	parameter int REC_CYC = `DPSEM_RECOVER_CYC
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              cmdValid,
	output logic                   cmdReady,
	input  wire dpsem_cmd_t        cmdOp,
	input  wire logic [2:0]        cmdIndex,
	output logic                   rspValid,
	output logic                   rspGranted,
	output logic                   initBusy,
	output logic                   semaphoreSelectN,
	output logic                   outputEnableN,
	output logic                   writeN,
	output logic [2:0]             flagIndexLines,
	output logic [DATA_W-1:0]      dataOut,
	output logic                   dataOe,
	input  wire logic [DATA_W-1:0] dataIn
);
	initial begin
		if (`DPSEM_FLAG_COUNT != (1 << `DPSEM_INDEX_W))
			$error("dpsem_host: flag count mismatch");
	end

	dpsem_cyc_if cyc ();

	dpsem_pin_cycle #(
		.DATA_W  (DATA_W),
		.ACC_CYC (ACC_CYC),
		.REC_CYC (REC_CYC)
	) u_pins (
		.clk              (clk),
		.rstn             (rstn),
		.cyc              (cyc),
		.semaphoreSelectN (semaphoreSelectN),
		.outputEnableN    (outputEnableN),
		.writeN           (writeN),
		.flagIndexLines   (flagIndexLines),
		.dataOut          (dataOut),
		.dataOe           (dataOe),
		.dataIn           (dataIn)
	);

	dpsem_state_t state_r;
	dpsem_cmd_t   op_r;
	logic [2:0]   idx_r;
	logic         granted_r;
	logic         start_r;
	logic         rspValid_r;
	logic         initBusy_r;

	// Claim, release and init write zero or one; poll only reads
	function automatic logic needsWrite(input dpsem_cmd_t op);
		return op != DPSEM_CMD_POLL;
	endfunction : needsWrite

	function automatic logic needsRead(input dpsem_cmd_t op);
		return op == DPSEM_CMD_CLAIM || op == DPSEM_CMD_POLL;
	endfunction : needsRead

	assign cmdReady   = (state_r == DPSEM_IDLE) && !initBusy_r;
	assign rspValid   = rspValid_r;
	assign rspGranted = granted_r;
	assign initBusy   = initBusy_r;

	assign cyc.start   = start_r;
	assign cyc.isWrite = (state_r == DPSEM_WRITE);
	assign cyc.index   = idx_r;
	// Claim writes zero, release and init write one
	assign cyc.wrBit   = (op_r != DPSEM_CMD_CLAIM);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r    <= DPSEM_IDLE;
			op_r       <= DPSEM_CMD_INIT;
			idx_r      <= 3'h0;
			granted_r  <= 1'b0;
			start_r    <= 1'b0;
			rspValid_r <= 1'b0;
			initBusy_r <= 1'b1;
		end else begin
			start_r    <= 1'b0;
			rspValid_r <= 1'b0;
			case (state_r)
				DPSEM_IDLE: begin
					if (initBusy_r) begin
						// Device latches start undefined; free all
						op_r    <= DPSEM_CMD_INIT;
						state_r <= DPSEM_WRITE;
						start_r <= 1'b1;
					end else if (cmdValid) begin
						op_r    <= cmdOp;
						idx_r   <= cmdIndex;
						start_r <= 1'b1;
						state_r <= needsWrite(cmdOp) ? DPSEM_WRITE
							: DPSEM_READ;
					end
				end
				DPSEM_WRITE: begin
					if (cyc.done) begin
						if (needsRead(op_r)) begin
							// Write first, then verify by reading
							state_r <= DPSEM_GAP;
						end else begin
							state_r <= DPSEM_DONE;
						end
					end
				end
				DPSEM_GAP: begin
					start_r <= 1'b1;
					state_r <= DPSEM_READ;
				end
				DPSEM_READ: begin
					if (cyc.done) begin
						// Zero read back means this side owns it
						granted_r <= !cyc.rdBit;
						state_r   <= DPSEM_DONE;
					end
				end
				DPSEM_DONE: begin
					state_r <= DPSEM_IDLE;
					// A user init command answers like a release
					if (initBusy_r) begin
						idx_r <= idx_r + 3'h1;
						if (idx_r == 3'(`DPSEM_FLAG_COUNT - 1))
							initBusy_r <= 1'b0;
					end else begin
						// Failure leaves a pending request; user must
						// poll or release it
						if (!needsRead(op_r))
							granted_r <= 1'b0;
						rspValid_r <= 1'b1;
					end
				end
				default: state_r <= DPSEM_IDLE;
			endcase
		end
	end
endmodule : dpsem_host

/* verif/dpsem_host_assertions.sv */
// Checker of the semaphore host pin protocol
`timescale 1ns/1ps
module dpsem_host_assertions import dpsem_pkg::*; #(
	parameter int DATA_W = 16
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              cmdValid,
	input wire logic              cmdReady,
	input wire dpsem_cmd_t        cmdOp,
	input wire logic              rspGranted,
	input wire logic              initBusy,
	input wire logic              semaphoreSelectN,
	input wire logic              outputEnableN,
	input wire logic              writeN,
	input wire logic [2:0]        flagIndexLines,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic              dataOe
);
	logic [3:0] initW;
	logic       wasW;
	wire        take = cmdValid && cmdReady;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			initW <= 4'h0;
			wasW  <= 1'b1;
		end else begin
			wasW <= writeN;
			if (initBusy && wasW && !writeN && dataOut[0])
				initW <= initW + 4'h1;
		end
	end
	property p_claim;
		take && cmdOp == DPSEM_CMD_CLAIM |->
			##[1:3] !writeN && !semaphoreSelectN && dataOut == '0;
	endproperty
	a_claim: assert property (p_claim) else $error("claim write bad");
	property p_rel;
		take && cmdOp == DPSEM_CMD_RELEASE |-> ##[1:3] !writeN && dataOut == '1;
	endproperty
	a_rel: assert property (p_rel) else $error("release write bad");
	property p_wr;
		!writeN |-> dataOe && !semaphoreSelectN
			&& (dataOut == '0 || dataOut == '1);
	endproperty
	a_wr: assert property (p_wr) else $error("write data bad");
	property p_rd;
		!outputEnableN |-> writeN && !dataOe;
	endproperty
	a_rd: assert property (p_rd) else $error("read drives data");
	property p_gap;
		$rose(semaphoreSelectN) |-> semaphoreSelectN[*2];
	endproperty
	a_gap: assert property (p_gap) else $error("select gap short");
	property p_init;
		initBusy |-> !cmdReady && (writeN || dataOut == '1);
	endproperty
	a_init: assert property (p_init) else $error("ready during init");
	property p_initAll;
		$fell(initBusy) |-> initW == 4'h8;
	endproperty
	a_initAll: assert property (p_initAll) else $error("init count");
	property p_idx;
		!semaphoreSelectN && !$past(semaphoreSelectN) |-> $stable(flagIndexLines);
	endproperty
	a_idx: assert property (p_idx) else $error("index moved");
	c_claim: cover property (take && cmdOp == DPSEM_CMD_CLAIM);
	c_grant: cover property ($rose(rspGranted));
	c_init: cover property ($fell(initBusy));
endmodule : dpsem_host_assertions
bind dpsem_host dpsem_host_assertions #(.DATA_W(DATA_W))
	u_dpsem_host_assertions (
	.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.cmdOp(cmdOp), .rspGranted(rspGranted), .initBusy(initBusy),
	.semaphoreSelectN(semaphoreSelectN), .outputEnableN(outputEnableN),
	.writeN(writeN), .flagIndexLines(flagIndexLines), .dataOut(dataOut),
	.dataOe(dataOe));

/* verif/dpsem_dev_model.sv */
// Behavioural two-port semaphore device: host left, bench right
`timescale 1ns/1ps
module dpsem_dev_model #(
	parameter int DATA_W = 16
) (
	input  wire logic              clk,
	input  wire logic              semaphoreSelectN,
	input  wire logic              outputEnableN,
	input  wire logic              writeN,
	input  wire logic [2:0]        flagIndexLines,
	input  wire logic [DATA_W-1:0] dataOut,
	output logic      [DATA_W-1:0] dataIn,
	input  wire logic              rWr,
	input  wire logic [2:0]        rIdx,
	input  wire logic              rBit,
	output logic      [7:0]        ownR
);
	// Left latches start requesting, so a host that skips init finds flags held
	logic [7:0] reqL = 8'h00;
	logic [7:0] reqR = 8'hff;
	logic [7:0] ownL = 8'hff;
	logic       held = 1'b0;
	logic       rdOn = 1'b0;
	logic       tog  = 1'b0;
	logic [7:0] ownRi = 8'h00;
	assign ownR = ownRi;
	// Undriven bus toggles so a stale value is never read as valid
	assign dataIn = rdOn ? {DATA_W{held}} : {DATA_W{tog}};
	always @(posedge clk) begin
		tog  <= !tog;
		rdOn <= !semaphoreSelectN && !outputEnableN;
		if (!semaphoreSelectN && !outputEnableN && !rdOn)
			held <= !ownL[flagIndexLines];
		if (!semaphoreSelectN && !writeN)
			reqL[flagIndexLines] <= dataOut[0];
		if (rWr)
			reqR[rIdx] <= rBit;
		for (int i = 0; i < 8; i++) begin
			case ({ownL[i], ownRi[i]})
				2'b10: if (reqL[i]) {ownL[i], ownRi[i]} <= {1'b0, !reqR[i]};
				2'b01: if (reqR[i]) {ownL[i], ownRi[i]} <= {!reqL[i], 1'b0};
				default: {ownL[i], ownRi[i]} <= {!reqL[i], reqL[i] & !reqR[i]};
			endcase
		end
	end
endmodule : dpsem_dev_model

/* verif/tb_dpsem_host.sv */
// Self-checking bench of the semaphore host against a device model
`timescale 1ns/1ps
module tb_dpsem_host import dpsem_pkg::*;;
	typedef struct packed {dpsem_cmd_t op; logic [2:0] ix; logic [1:0] ra; logic ex;} dpsem_row_t;
	logic clk, rstn, cmdValid, cmdReady, rspValid, rspGranted, initBusy;
	logic semN, oeN, wrN, dataOe, rWr, rBit;
	logic [2:0] cmdIndex, flagIx, rIdx;
	logic [15:0] dOut, dIn;
	logic [7:0] ownR;
	dpsem_cmd_t cmdOp;
	int err_total = 0;
	int compares = 0;
	dpsem_row_t rows [10] = '{
		'{DPSEM_CMD_CLAIM, 3'h0, 2'h0, 1'b1}, '{DPSEM_CMD_POLL, 3'h0, 2'h0, 1'b1},
		'{DPSEM_CMD_RELEASE, 3'h0, 2'h0, 1'b0}, '{DPSEM_CMD_CLAIM, 3'h1, 2'h1, 1'b0},
		'{DPSEM_CMD_POLL, 3'h1, 2'h0, 1'b0}, '{DPSEM_CMD_POLL, 3'h1, 2'h2, 1'b1},
		'{DPSEM_CMD_RELEASE, 3'h1, 2'h0, 1'b0}, '{DPSEM_CMD_INIT, 3'h7, 2'h0, 1'b0},
		'{DPSEM_CMD_CLAIM, 3'h7, 2'h0, 1'b1}, '{DPSEM_CMD_RELEASE, 3'h7, 2'h0, 1'b0}};
	dpsem_host u_dpsem_host (.clk(clk), .rstn(rstn), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdOp(cmdOp), .cmdIndex(cmdIndex),
		.rspValid(rspValid), .rspGranted(rspGranted), .initBusy(initBusy),
		.semaphoreSelectN(semN), .outputEnableN(oeN), .writeN(wrN),
		.flagIndexLines(flagIx), .dataOut(dOut), .dataOe(dataOe), .dataIn(dIn));
	dpsem_dev_model u_dpsem_dev_model (.clk(clk), .semaphoreSelectN(semN),
		.outputEnableN(oeN), .writeN(wrN), .flagIndexLines(flagIx),
		.dataOut(dOut), .dataIn(dIn), .rWr(rWr), .rIdx(rIdx), .rBit(rBit),
		.ownR(ownR));
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic ex, input logic got);
		compares++;
		if (got !== ex) begin
			$display("MISMATCH %s exp %b got %b", nm, ex, got);
			err_total++;
		end
	endtask : chk
	task automatic waitfor(ref logic s);
		int n;
		n = 0;
		@(negedge clk);
		while (s !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			wrap_up();
		end
	endtask : waitfor
	task automatic run(input dpsem_cmd_t op, input logic [2:0] ix);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdOp    <= op;
		cmdIndex <= ix;
		waitfor(cmdReady);
		@(posedge clk);
		cmdValid <= 1'b0;
		waitfor(rspValid);
	endtask : run
	// Right port acts as the other processor, keeping claim and release order
	task automatic rside(input logic [2:0] ix, input logic b);
		@(posedge clk);
		rWr  <= 1'b1;
		rIdx <= ix;
		rBit <= b;
		@(posedge clk);
		rWr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : rside
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rstn, cmdValid, rWr, rIdx, cmdIndex} = '0;
		rBit  = 1'b1;
		cmdOp = DPSEM_CMD_POLL;
		repeat (4) @(posedge clk);
		chk("initBusy", 1'b1, initBusy);
		chk("semN", 1'b1, semN);
		rstn <= 1'b1;
		waitfor(cmdReady);
		chk("initBusy", 1'b0, initBusy);
		for (int i = 0; i < 10; i++) begin
			if (rows[i].ra != 2'h0)
				rside(rows[i].ix, rows[i].ra[1]);
			run(rows[i].op, rows[i].ix);
			chk("rspGranted", rows[i].ex, rspGranted);
			$display("row %0d done", i);
		end
		fork
			run(DPSEM_CMD_CLAIM, 3'h3);
			rside(3'h3, 1'b0);
		join
		chk("oneOwner", 1'b1, rspGranted ^ ownR[3]);
		rside(3'h3, 1'b1);
		run(DPSEM_CMD_POLL, 3'h3);
		chk("handover", 1'b1, rspGranted);
		run(DPSEM_CMD_RELEASE, 3'h3);
		chk("released", 1'b0, rspGranted);
		$display("contention test done");
		// Mid-run reset must free a flag the host still holds
		run(DPSEM_CMD_CLAIM, 3'h5);
		chk("preReset", 1'b1, rspGranted);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("rstBusy", 1'b1, initBusy);
		chk("rstSemN", 1'b1, semN);
		rstn <= 1'b1;
		waitfor(cmdReady);
		rside(3'h5, 1'b0);
		chk("rightGets", 1'b1, ownR[5]);
		run(DPSEM_CMD_POLL, 3'h5);
		chk("freed", 1'b0, rspGranted);
		rside(3'h5, 1'b1);
		$display("reset test done");
		wrap_up();
	end
endmodule : tb_dpsem_host
